// ### pwm_load_model.sv
// External load on the PWM pad: measures high time and period in clocks
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic mclk,
  input wire logic padLevel,
  output int highLen,
  output int periodLen
);
  int cnt = 0;
  int hi = 0;
  logic last = 1'b0;
  // A rising pad closes one period and opens the next
  always @(posedge mclk) begin
    // Outputs move by non-blocking update so a reader at this edge sees a settled value
    if (padLevel && !last) begin
      highLen <= hi;
      periodLen <= cnt;
      cnt = 0;
      hi = 0;
    end
    cnt++;
    if (padLevel) hi++;
    last = padLevel;
  end
endmodule

// ### pwm_pin_stage.sv
// PWM output latch: set on period rollover, cleared on duty match or when off
`timescale 1ns/1ps
module pwm_pin_stage (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic rollover,
  input wire logic dutyZero,
  input wire logic clearMatch,
  output logic pin
);

  typedef struct packed {
    logic pin;
  } pin_state_t;

  pin_state_t st_r;
  pin_state_t st_nxt;

  // Off forces low, rollover sets unless duty is zero, match clears
  always_comb begin
    st_nxt = st_r;
    if (!enable) begin
      st_nxt.pin = 1'b0;
    end else if (rollover) begin
      st_nxt.pin = !dutyZero;
    end else if (clearMatch) begin
      st_nxt.pin = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin = st_r.pin;

endmodule

// ### pwm_pkg.sv
// Shared constants for the PWM unit: register map, fields, reset values, timing
package pwm_pkg;

  // APB address width and register indices (byte address is four times the index)
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_GLOBAL_IRQ_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_TIMEBASE_COUNT = 8'h11;
  localparam logic [7:0] IDX_TIMEBASE_CONTROL = 8'h12;
  localparam logic [7:0] IDX_DUTY_REQUEST_LOW = 8'h15;
  localparam logic [7:0] IDX_DUTY_ACTIVE_HIGH = 8'h16;
  localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] IDX_PORT_DIRECTION = 8'h86;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hff;

  // Field positions
  localparam int MATCH_FLAG_BIT = 1;
  localparam int RUN_BIT = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int POSTSCALE_LSB = 3;
  localparam int DUTY_LSB_FIELD = 4;
  localparam int PIN_DIR_BIT = 3;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Timing: oscillator period and quarter phases per timebase increment
  localparam int TOSC_NS = 20;
  localparam int QUARTERS = 4;
  localparam int DIV_W = 6;
  localparam logic [2:0] SHIFT_PS1 = 3'h0;
  localparam logic [2:0] SHIFT_PS4 = 3'h2;
  localparam logic [2:0] SHIFT_PS16 = 3'h4;

endpackage

// ### pwm_prescaler.sv
// Timebase divider: quarter phase and 1/4/16 prescale, gives tick, step and phase
`timescale 1ns/1ps
module pwm_prescaler #(
  parameter int DIV_W = pwm_pkg::DIV_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic clr,
  input wire logic [1:0] sel,
  output logic tick,
  output logic step,
  output logic [1:0] phase
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;
  logic [2:0] shift;
  logic [DIV_W-1:0] mask;
  logic [DIV_W-1:0] last;

  // Ratio select decode
  always_comb begin
    case (sel)
      2'b00: shift = pwm_pkg::SHIFT_PS1;
      2'b01: shift = pwm_pkg::SHIFT_PS4;
      default: shift = pwm_pkg::SHIFT_PS16;
    endcase
    mask = DIV_W'((1 << shift) - 1);
    last = DIV_W'((pwm_pkg::QUARTERS << shift) - 1);
    tick = run && (st_r.div >= last);
    step = run && ((st_r.div & mask) == mask);
    phase = 2'(st_r.div >> shift);
  end

  // Divider advances only while running, restarts on clear
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.div = '0;
    end else if (tick) begin
      st_nxt.div = '0;
    end else if (run) begin
      st_nxt.div = DIV_W'(st_r.div + 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ### pwm_unit.sv
// Double-buffered 10-bit PWM unit with timebase and APB register slave
//
// Behaviour
// - Period is (limit+1) x 4 x prescale clocks
// - Count equal to limit clears on increment
// - Rollover sets pin unless duty is zero
// - Rollover copies pending duty into active duty
// - Postscale field never alters PWM period
// - Duty is low byte plus control bits 5:4
// - High time is duty x prescale clocks
// - Duty writes act only after next rollover
// - Active duty read-only while in PWM mode
// - Active duty held in register plus latch
// - Pin clears when extended count meets duty
// - Duty beyond period keeps pin high throughout
// - Prescale ratios are 1, 4 and 16
// - Mode zero switches unit off and resets
// - Cleared control forces output latch low
`timescale 1ns/1ps
module pwm_unit (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwmPin,
  output logic pwmPinOe
);

  typedef struct packed {
    logic [7:0] irqCtl;
    logic matchFlag;
    logic [7:0] count;
    logic [6:0] tbCtl;
    logic [7:0] dutyReq;
    logic [7:0] dutyAct;
    logic [1:0] dutyLat;
    logic [5:0] unitCtl;
    logic [7:0] portDir;
    logic [7:0] irqEn;
    logic [7:0] period;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pinOe;
  } unit_state_t;

  unit_state_t st_r;
  unit_state_t st_nxt;

  // Prescaler and pin stage hookup
  logic tick;
  logic step;
  logic [1:0] phase;
  logic pinQ;
  logic clrDiv;
  logic pinEnable;
  logic tbWrap;
  logic clearMatch;
  logic dutyZero;

  // Bus decode
  logic access;
  logic done;
  logic wr;
  logic [8:0] rdSel;
  logic [7:0] wIdx;
  logic [7:0] wByte;

  // Mode and duty views
  logic pwmMode;
  logic periodHit;
  logic [9:0] dutyReqFull;
  logic [9:0] dutyActFull;
  logic [9:0] extNext;

  // Word address to register index, valid only when aligned and in range
  function automatic logic [8:0] addrIndex(input logic [pwm_pkg::ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'b00) && (a[pwm_pkg::ADDR_W-1:10] == '0);
    return {ok, a[9:2]};
  endfunction

  // Read value of one register; top bit says whether it exists
  function automatic logic [8:0] readByte(input unit_state_t s, input logic [8:0] ai);
    logic [8:0] r;
    r = {1'b0, pwm_pkg::RST_ZERO};
    if (ai[8]) begin
      case (ai[7:0])
        pwm_pkg::IDX_GLOBAL_IRQ_CONTROL: r = {1'b1, s.irqCtl};
        pwm_pkg::IDX_PERIPHERAL_FLAGS: begin
          r = {1'b1, pwm_pkg::RST_ZERO};
          r[pwm_pkg::MATCH_FLAG_BIT] = s.matchFlag;
        end
        pwm_pkg::IDX_TIMEBASE_COUNT: r = {1'b1, s.count};
        pwm_pkg::IDX_TIMEBASE_CONTROL: r = {2'b10, s.tbCtl};
        pwm_pkg::IDX_DUTY_REQUEST_LOW: r = {1'b1, s.dutyReq};
        pwm_pkg::IDX_DUTY_ACTIVE_HIGH: r = {1'b1, s.dutyAct};
        pwm_pkg::IDX_UNIT_CONTROL: r = {3'b100, s.unitCtl};
        pwm_pkg::IDX_PORT_DIRECTION: r = {1'b1, s.portDir};
        pwm_pkg::IDX_PERIPHERAL_IRQ_ENABLES: r = {1'b1, s.irqEn};
        pwm_pkg::IDX_PERIOD_LIMIT: r = {1'b1, s.period};
        default: r = {1'b0, pwm_pkg::RST_ZERO};
      endcase
    end
    return r;
  endfunction

  // APB phases: answer comes one cycle into the access phase
  assign access = psel && penable && !st_r.pready;
  assign done = psel && penable && st_r.pready;
  assign rdSel = readByte(st_r, addrIndex(paddr));
  assign wr = done && pwrite && rdSel[8];
  assign wIdx = paddr[9:2];
  assign wByte = pwdata[7:0];

  assign pwmMode = st_r.unitCtl[3:2] == pwm_pkg::MODE_PWM_TOP;

  assign dutyReqFull = {st_r.dutyReq, st_r.unitCtl[pwm_pkg::DUTY_LSB_FIELD +: 2]};
  assign dutyActFull = {st_r.dutyAct, st_r.dutyLat};
  assign dutyZero = dutyReqFull == '0;

  assign periodHit = st_r.count == st_r.period;
  assign tbWrap = tick && periodHit;

  // high time counts duty in prescaled quarters
  // next extended count compared with active duty
  assign extNext = 10'({st_r.count, phase} + 10'h001);

  // a duty beyond the period never produces a match
  assign clearMatch = step && !tbWrap && (extNext == dutyActFull);

  // Divider restarts when software rewrites the count or its control
  assign clrDiv = wr && ((wIdx == pwm_pkg::IDX_TIMEBASE_COUNT)
    || (wIdx == pwm_pkg::IDX_TIMEBASE_CONTROL));

  // output stage follows the mode being written this cycle
  assign pinEnable = st_nxt.unitCtl[3:2] == pwm_pkg::MODE_PWM_TOP;

  pwm_prescaler #(
    .DIV_W(pwm_pkg::DIV_W)
  ) u_prescaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(st_r.tbCtl[pwm_pkg::RUN_BIT]),
    .clr(clrDiv),
    .sel(st_r.tbCtl[pwm_pkg::PRESCALE_LSB +: 2]),
    .tick(tick),
    .step(step),
    .phase(phase)
  );

  // pin set at rollover, cleared at match
  pwm_pin_stage u_pin_stage (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(pinEnable),
    .rollover(tbWrap),
    .dutyZero(dutyZero),
    .clearMatch(clearMatch),
    .pin(pinQ)
  );

  // Next state of the whole unit
  always_comb begin
    st_nxt = st_r;

    // Bus answer, registered so outputs come from flops
    st_nxt.pready = access;
    st_nxt.pslverr = access && !rdSel[8];
    if (access) begin
      st_nxt.prdata = {24'h00_0000, rdSel[7:0]};
    end

    // count steps on each divider tick
    if (tick) begin
      if (periodHit) begin
        st_nxt.count = pwm_pkg::RST_ZERO;
      end else begin
        st_nxt.count = 8'(st_r.count + 8'h01);
      end
    end

    if (tbWrap && pwmMode) begin
      // high byte plus hidden two-bit latch
      st_nxt.dutyAct = st_r.dutyReq;
      st_nxt.dutyLat = st_r.unitCtl[pwm_pkg::DUTY_LSB_FIELD +: 2];
    end

    // Register writes at the completing APB edge
    if (wr) begin
      case (wIdx)
        pwm_pkg::IDX_GLOBAL_IRQ_CONTROL: st_nxt.irqCtl = wByte;
        pwm_pkg::IDX_PERIPHERAL_FLAGS: st_nxt.matchFlag = wByte[pwm_pkg::MATCH_FLAG_BIT];
        pwm_pkg::IDX_TIMEBASE_COUNT: st_nxt.count = wByte;
        pwm_pkg::IDX_TIMEBASE_CONTROL: st_nxt.tbCtl = wByte[6:0];
        pwm_pkg::IDX_DUTY_REQUEST_LOW: st_nxt.dutyReq = wByte;
        pwm_pkg::IDX_DUTY_ACTIVE_HIGH: begin
          if (!pwmMode) begin
            st_nxt.dutyAct = wByte;
          end
        end
        pwm_pkg::IDX_UNIT_CONTROL: begin
          st_nxt.unitCtl = wByte[5:0];
          if (wByte[3:0] == pwm_pkg::MODE_OFF) begin
            st_nxt.dutyAct = pwm_pkg::RST_ZERO;
            st_nxt.dutyLat = 2'b00;
          end
        end
        pwm_pkg::IDX_PORT_DIRECTION: st_nxt.portDir = wByte;
        pwm_pkg::IDX_PERIPHERAL_IRQ_ENABLES: st_nxt.irqEn = wByte;
        pwm_pkg::IDX_PERIOD_LIMIT: st_nxt.period = wByte;
        default: st_nxt.irqCtl = st_r.irqCtl;
      endcase
    end

    // match flag set, winning over a same-cycle clear
    if (tbWrap) begin
      st_nxt.matchFlag = 1'b1;
    end

    // Pin driven while its direction bit is clear
    st_nxt.pinOe = !st_nxt.portDir[pwm_pkg::PIN_DIR_BIT];
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.period <= pwm_pkg::RST_PERIOD_LIMIT;
      st_r.portDir <= pwm_pkg::RST_PORT_DIRECTION;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pwmPin = pinQ;
  assign pwmPinOe = st_r.pinOe;

endmodule

// ### pwm_unit_monitor.sv
// Port checker for the PWM unit, bound to its top module
`timescale 1ns/1ps
module pwm_unit_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwmPin,
  input wire logic pwmPinOe
);
  logic wrDone, dirHit, pwmOn_r;
  // Completed writes, and the one that reaches the direction register
  assign wrDone = psel && penable && pready && pwrite;
  assign dirHit = wrDone && paddr == 12'h218;
  // Mode as software last wrote it
  always_ff @(posedge mclk) begin
    if (sys_rst) pwmOn_r <= 1'b0;
    else if (wrDone && paddr == 12'h05c) pwmOn_r <= pwdata[3:2] == 2'b11;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence setupThenAccess;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence dirWrite;
    dirHit;
  endsequence
  ready_latency_a: assert property (setupThenAccess |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  setup_idle_a: assert property (psel && !penable |-> !pready)
    else $error("ready during setup");
  err_quiet_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  dir_oe_a: assert property (dirWrite |-> ##2 pwmPinOe == !$past(pwdata[3], 2))
    else $error("drive enable not from direction bit");
  oe_cause_a: assert property ($changed(pwmPinOe) |-> $past(dirHit) || $past(dirHit, 2))
    else $error("drive enable moved on its own");
  off_pin_a: assert property (!pwmOn_r && !$past(pwmOn_r) |-> !pwmPin)
    else $error("pin high outside output mode");
  rise_mode_a: assert property ($rose(pwmPin) |-> pwmOn_r)
    else $error("pin rose outside output mode");
endmodule

bind pwm_unit pwm_unit_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwmPin(pwmPin), .pwmPinOe(pwmPinOe));

// ### testbench.sv
// Self-checking bench for the PWM unit
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pwmPin, pwmPinOe, err;
  int highLen, periodLen;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // Pad has a pull-down, so an undriven pin reads low
  wire logic padLevel = pwmPinOe ? pwmPin : 1'b0;
  always #10 mclk = ~mclk;
  pwm_unit DUT (.mclk(mclk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmPin(pwmPin), .pwmPinOe(pwmPinOe));
  pwm_load_model load (.mclk(mclk), .padLevel(padLevel), .highLen(highLen),
    .periodLen(periodLen));
  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %0h not %0h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, access until ready, then release
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= w;
    pwdata <= 32'(d);
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(i, 1'b1, d);
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [7:0] x);
    apb(i, 1'b0, 8'h00);
    chk(rd, 32'(x));
  endtask
  // Reset values and an unmapped place
  task automatic resetVals;
    rdchk(pwm_pkg::IDX_PERIOD_LIMIT, 8'hff);
    rdchk(pwm_pkg::IDX_PORT_DIRECTION, 8'hff);
    rdchk(pwm_pkg::IDX_UNIT_CONTROL, 8'h00);
    apb(8'h01, 1'b0, 8'h00);
    chk(err, 1);
  endtask
  // Period, duty, direction, timebase, then mode, in that order
  task automatic start(input logic [7:0] lim, input logic [9:0] duty, input logic [7:0] tbc,
      input logic [3:0] md);
    wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h00);
    // Stop and clear the timebase: a count above the new limit would run on to wrap
    wr(pwm_pkg::IDX_TIMEBASE_CONTROL, 8'h00);
    wr(pwm_pkg::IDX_TIMEBASE_COUNT, 8'h00);
    wr(pwm_pkg::IDX_PERIOD_LIMIT, lim);
    wr(pwm_pkg::IDX_DUTY_REQUEST_LOW, duty[9:2]);
    wr(pwm_pkg::IDX_UNIT_CONTROL, {2'b00, duty[1:0], 4'h0});
    wr(pwm_pkg::IDX_PORT_DIRECTION, 8'hf7);
    wr(pwm_pkg::IDX_TIMEBASE_CONTROL, tbc);
    wr(pwm_pkg::IDX_UNIT_CONTROL, {2'b00, duty[1:0], md});
  endtask
  // Waveform shape for one prescale ratio and mode code
  task automatic shape(input logic [7:0] lim, input logic [9:0] duty, input logic [3:0] md,
      input int ps, input logic [7:0] post);
    logic [7:0] tbc;
    tbc = post | 8'h04 | (ps == 16 ? 8'h02 : ps == 4 ? 8'h01 : 8'h00);
    start(lim, duty, tbc, md);
    repeat (3 * (lim + 1) * 4 * ps) @(posedge mclk);
    chk(highLen, duty * ps);
    chk(periodLen, (lim + 1) * 4 * ps);
  endtask
  // New duty waits for the next rollover
  task automatic dutySwap;
    wr(pwm_pkg::IDX_DUTY_REQUEST_LOW, 8'h02);
    @(posedge padLevel);
    repeat (2) @(posedge mclk);
    chk(highLen, 5);
    @(posedge padLevel);
    repeat (2) @(posedge mclk);
    chk(highLen, 9);
    wr(pwm_pkg::IDX_DUTY_ACTIVE_HIGH, 8'haa);
    rdchk(pwm_pkg::IDX_DUTY_ACTIVE_HIGH, 8'h02);
    apb(pwm_pkg::IDX_PERIPHERAL_FLAGS, 1'b0, 8'h00);
    chk(rd[1], 1);
  endtask
  // Pad held at one level for two whole periods
  task automatic steady(input logic [9:0] duty, input logic lvl);
    int bad;
    bad = 0;
    start(8'h03, duty, 8'h04, 4'hf);
    repeat (32) @(posedge mclk);
    repeat (32) begin
      @(posedge mclk);
      if (padLevel !== lvl) bad++;
    end
    chk(bad, 0);
  endtask
  // Stop the timebase, then switch the unit off
  task automatic switchOff;
    logic [7:0] c0;
    wr(pwm_pkg::IDX_TIMEBASE_CONTROL, 8'h00);
    apb(pwm_pkg::IDX_TIMEBASE_COUNT, 1'b0, 8'h00);
    c0 = rd[7:0];
    repeat (10) @(posedge mclk);
    rdchk(pwm_pkg::IDX_TIMEBASE_COUNT, c0);
    wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h00);
    @(posedge mclk);
    chk(pwmPin, 0);
    rdchk(pwm_pkg::IDX_DUTY_ACTIVE_HIGH, 8'h00);
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      $display("wrong value at %0t: run timed out", $time);
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    resetVals();
    shape(8'h03, 10'h005, 4'hc, 1, 8'h00);
    dutySwap();
    shape(8'h01, 10'h003, 4'hd, 4, 8'h78);
    shape(8'h00, 10'h002, 4'he, 16, 8'h28);
    steady(10'h000, 1'b0);
    steady(10'h010, 1'b1);
    switchOff();
    give_verdict();
  end
endmodule
